// file: design/rbc_pkg.sv
// Purpose: shared constants for the ram self-test control block
// Assumes: 25 MHz device clock, 8K x 16 internal ram
// Notes: self-test control register sits at host register address 0x28
package rbc_pkg;
   localparam logic [7:0] REG_SELF_TEST_ADDR = 8'h28;
   localparam int FULL_RAM_ACCESS_POS = 15;
   localparam int FORCE_FAIL_POS = 14;
   localparam int BIST_SELECT_LSB = 11;
   localparam int BIST_GO_POS = 10;
   localparam int BIST_PASS_POS = 9;
   localparam int BIST_FAIL_POS = 8;
   localparam logic [15:0] REG_RESET_VALUE = 16'h0000;
   localparam logic [2:0] SEL_IDLE_LO = 3'h0;
   localparam logic [2:0] SEL_PATTERN = 3'h1;
   localparam logic [2:0] SEL_WRITE_ZERO = 3'h2;
   localparam logic [2:0] SEL_CHECK_ZERO = 3'h3;
   localparam logic [2:0] SEL_WRITE_ONE = 3'h4;
   localparam logic [2:0] SEL_CHECK_ONE = 3'h5;
   localparam logic [2:0] SEL_INC_DEC = 3'h6;
   localparam logic [15:0] DATA_ZERO = 16'h0000;
   localparam logic [15:0] DATA_ONE = 16'hFFFF;
   localparam logic [15:0] PAT_ALT = 16'h5555;
   localparam logic [15:0] PAT_PAIR = 16'h3333;
   localparam logic [15:0] PAT_NIB = 16'h0F0F;
   localparam logic [15:0] PAT_NIB_INV = 16'hF0F0;
   localparam logic [12:0] RAM_TOP = 13'h1FFF;
   localparam logic [12:0] HOST_LOW_LIMIT = 13'h0052;
   localparam int CLK_PERIOD_NS = 40;
   localparam int PATTERN_TIME_NS = 14420000;
   localparam int PATTERN_CYCLES = (PATTERN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : rbc_pkg

// file: design/rbc_reset_sync.sv
// Purpose: two-stage release of the asynchronous reset
// Assumes: i_rstn active low, asserted asynchronously
// Notes: assertion is immediate, release waits two edges
`timescale 1ns/1ns
`default_nettype none
module rbc_reset_sync
(
   input wire logic i_clk,
   input wire logic i_rstn,
   output logic o_rstn
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= 1'b1;
         sync_reg <= meta_reg;
      end
   end

   assign o_rstn = sync_reg;
endmodule : rbc_reset_sync
`default_nettype wire

// file: design/rbc_ram.sv
// Purpose: single-port internal static ram with registered read
// Assumes: one access per cycle, read data valid the cycle after
// Notes: no reset on the array; contents are undefined at power-up
`timescale 1ns/1ns
`default_nettype none
module rbc_ram
#(
   parameter int ADDR_W = 13,
   parameter int DATA_W = 16
)
(
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   output logic [DATA_W-1:0] o_rdata
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] rdata_reg;

   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem[i_addr] <= i_wdata;
      end
      rdata_reg <= mem[i_addr];
   end

   assign o_rdata = rdata_reg;
endmodule : rbc_ram
`default_nettype wire

// file: design/rbc_bist_ctrl.sv
// Purpose: ram built-in self-test control and self-test control register
// Assumes: host register port already decoded from the serial host port
// Notes: tests are destructive; host ram port is locked out while busy
// Functional notes
// - select code 001 runs the multi-step pattern test on start.
// - the pattern test also covers the 82 low words the host cannot write.
// - test accesses to the low ram range leave the host registers untouched.
// - the pattern test first writes zero to every word from 0x0000 to 0x1FFF.
// - per word, the test first reads and checks that the word is still zero.
// - per word, 0x5555, 0x3333 and 0x0F0F are written, read back and compared.
// - per word, 0xF0F0 is also written, read back and compared, failing on mismatch.
// - writing one to the go bit starts the test named by the select field.
// - the go bit is taken only with the test pin high and full ram access already set.
// - the go bit clears itself when the selected test finishes.
// - after completion the outcome shows in the pass and fail bits.
// - pass is set on clean finish without force fail, fail on error or force fail, both cleared at start.
// - codes 010..110 run write/check zeros, write/check ones and inc/dec; 000, 111 idle.
// - the self-test register works only while the test pin is high.
// - the pattern test takes about 14.42 ms before it reports.
`timescale 1ns/1ns
`default_nettype none
module rbc_bist_ctrl
#(
   parameter int PATTERN_CYCLES = rbc_pkg::PATTERN_CYCLES
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_test_pin,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   input wire logic i_ram_we,
   input wire logic [12:0] i_ram_addr,
   input wire logic [15:0] i_ram_wdata,
   output logic [15:0] o_ram_rdata,
   output logic o_bist_busy
);
   localparam int CW = $clog2(PATTERN_CYCLES + 1);
   localparam logic [CW-1:0] PAT_LIMIT = CW'(PATTERN_CYCLES);

   typedef enum {ST_IDLE, ST_FILL, ST_RD0, ST_CHK0, ST_PWR, ST_PRD, ST_PCHK, ST_HOLD}
      rbc_state_type;

   logic rstn;
   rbc_state_type state_reg, state_next;
   logic [12:0] addr_reg, addr_next;
   logic [1:0] pat_reg, pat_next;
   logic err_reg, err_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic full_ram_access_bit_reg, full_ram_access_bit_next;
   logic ffail_reg, ffail_next;
   logic [2:0] sel_reg, sel_next;
   logic go_reg, go_next;
   logic pass_reg, pass_next;
   logic fail_reg, fail_next;
   logic [15:0] rdata_reg, rdata_next;
   logic ram_we;
   logic [12:0] ram_addr;
   logic [15:0] ram_wdata;
   logic [15:0] ram_rdata;
   logic [15:0] pat_data;
   logic [15:0] fill_data;
   logic reg_hit;
   logic start;
   logic last_word;

   rbc_reset_sync u_reset_sync
   (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .o_rstn(rstn)
   );

   rbc_ram #(.ADDR_W(13), .DATA_W(16)) u_ram
   (
      .i_clk(i_clk),
      .i_we(ram_we),
      .i_addr(ram_addr),
      .i_wdata(ram_wdata),
      .o_rdata(ram_rdata)
   );

   // register only answers while the test pin is high
   assign reg_hit = i_test_pin && (i_reg_addr == rbc_pkg::REG_SELF_TEST_ADDR);
   // full_ram_access_bit_reg is the value before this write: it must already be set
   assign start = reg_hit && i_reg_wr && i_reg_wdata[rbc_pkg::BIST_GO_POS]
      && full_ram_access_bit_reg && (state_reg == ST_IDLE);
   assign last_word = (addr_reg == rbc_pkg::RAM_TOP);
   assign fill_data = (sel_reg == rbc_pkg::SEL_WRITE_ONE || sel_reg == rbc_pkg::SEL_CHECK_ONE)
      ? rbc_pkg::DATA_ONE : rbc_pkg::DATA_ZERO;

   always_comb
   begin
      case (pat_reg)
         2'd0: pat_data = rbc_pkg::PAT_ALT;
         2'd1: pat_data = rbc_pkg::PAT_PAIR;
         2'd2: pat_data = rbc_pkg::PAT_NIB;
         default: pat_data = rbc_pkg::PAT_NIB_INV;
      endcase
   end

   // ram port: the engine owns it while busy; host cannot write the low words
   always_comb
   begin
      ram_we = 1'b0;
      ram_addr = addr_reg;
      ram_wdata = fill_data;
      case (state_reg)
         ST_IDLE:
         begin
            ram_addr = i_ram_addr;
            ram_wdata = i_ram_wdata;
            ram_we = i_ram_we && (i_ram_addr >= rbc_pkg::HOST_LOW_LIMIT);
         end
         ST_FILL: ram_we = 1'b1;
         ST_PWR:
         begin
            ram_we = 1'b1;
            ram_wdata = pat_data;
         end
         default: ram_we = 1'b0;
      endcase
   end

   // test sequencer; the register flops live apart from the ram array
   always_comb
   begin
      state_next = state_reg;
      addr_next = addr_reg;
      pat_next = pat_reg;
      err_next = err_reg;
      cnt_next = (cnt_reg == PAT_LIMIT) ? cnt_reg : cnt_reg + CW'(1);
      case (state_reg)
         ST_IDLE:
         begin
            if (start)
            begin
               addr_next = '0;
               pat_next = '0;
               err_next = 1'b0;
               cnt_next = '0;
               case (i_reg_wdata[rbc_pkg::BIST_SELECT_LSB +: 3])
                  rbc_pkg::SEL_PATTERN: state_next = ST_FILL;
                  rbc_pkg::SEL_WRITE_ZERO: state_next = ST_FILL;
                  rbc_pkg::SEL_WRITE_ONE: state_next = ST_FILL;
                  rbc_pkg::SEL_CHECK_ZERO: state_next = ST_RD0;
                  rbc_pkg::SEL_CHECK_ONE: state_next = ST_RD0;
                  rbc_pkg::SEL_INC_DEC: state_next = ST_PWR;
                  default: state_next = ST_HOLD;
               endcase
            end
         end
         ST_FILL:
         begin
            addr_next = addr_reg + 13'd1;
            if (last_word)
            begin
               addr_next = '0;
               state_next = (sel_reg == rbc_pkg::SEL_PATTERN) ? ST_RD0 : ST_HOLD;
            end
         end
         ST_RD0: state_next = ST_CHK0;
         ST_CHK0:
         begin
            if (ram_rdata != fill_data)
            begin
               err_next = 1'b1;
            end
            if (sel_reg == rbc_pkg::SEL_PATTERN)
            begin
               state_next = ST_PWR;
               pat_next = '0;
            end
            else
            begin
               addr_next = addr_reg + 13'd1;
               state_next = last_word ? ST_HOLD : ST_RD0;
            end
         end
         ST_PWR: state_next = ST_PRD;
         ST_PRD: state_next = ST_PCHK;
         ST_PCHK:
         begin
            if (ram_rdata != pat_data)
            begin
               err_next = 1'b1;
            end
            pat_next = pat_reg + 2'd1;
            state_next = ST_PWR;
            if (pat_reg == 2'd3)
            begin
               addr_next = addr_reg + 13'd1;
               state_next = last_word ? ST_HOLD
                  : (sel_reg == rbc_pkg::SEL_PATTERN) ? ST_RD0 : ST_PWR;
            end
         end
         ST_HOLD:
         begin
            // pattern test reports no sooner than its nominal run time
            if (sel_reg != rbc_pkg::SEL_PATTERN || cnt_reg == PAT_LIMIT)
            begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= ST_IDLE;
         addr_reg <= '0;
         pat_reg <= '0;
         err_reg <= 1'b0;
         cnt_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         pat_reg <= pat_next;
         err_reg <= err_next;
         cnt_reg <= cnt_next;
      end
   end

   // self-test control register
   always_comb
   begin
      full_ram_access_bit_next = full_ram_access_bit_reg;
      ffail_next = ffail_reg;
      sel_next = sel_reg;
      go_next = go_reg;
      pass_next = pass_reg;
      fail_next = fail_reg;
      rdata_next = rdata_reg;
      // writes to the other fields are refused while a test runs
      if (reg_hit && i_reg_wr && state_reg == ST_IDLE)
      begin
         full_ram_access_bit_next = i_reg_wdata[rbc_pkg::FULL_RAM_ACCESS_POS];
         ffail_next = i_reg_wdata[rbc_pkg::FORCE_FAIL_POS];
         sel_next = i_reg_wdata[rbc_pkg::BIST_SELECT_LSB +: 3];
      end
      if (start)
      begin
         go_next = 1'b1;
         pass_next = 1'b0;
         fail_next = 1'b0;
      end
      if (state_reg == ST_HOLD && state_next == ST_IDLE)
      begin
         go_next = 1'b0;
         if (sel_reg != rbc_pkg::SEL_IDLE_LO && sel_reg != 3'h7)
         begin
            fail_next = err_reg || ffail_reg;
            pass_next = !(err_reg || ffail_reg);
         end
      end
      if (i_reg_rd)
      begin
         rdata_next = '0;
         if (reg_hit)
         begin
            rdata_next = {full_ram_access_bit_reg, ffail_reg, sel_reg, go_reg, pass_reg, fail_reg, 8'h00};
         end
      end
   end

   always_ff @(posedge i_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         full_ram_access_bit_reg <= rbc_pkg::REG_RESET_VALUE[rbc_pkg::FULL_RAM_ACCESS_POS];
         ffail_reg <= rbc_pkg::REG_RESET_VALUE[rbc_pkg::FORCE_FAIL_POS];
         sel_reg <= rbc_pkg::REG_RESET_VALUE[rbc_pkg::BIST_SELECT_LSB +: 3];
         go_reg <= rbc_pkg::REG_RESET_VALUE[rbc_pkg::BIST_GO_POS];
         pass_reg <= rbc_pkg::REG_RESET_VALUE[rbc_pkg::BIST_PASS_POS];
         fail_reg <= rbc_pkg::REG_RESET_VALUE[rbc_pkg::BIST_FAIL_POS];
         rdata_reg <= '0;
      end
      else
      begin
         full_ram_access_bit_reg <= full_ram_access_bit_next;
         ffail_reg <= ffail_next;
         sel_reg <= sel_next;
         go_reg <= go_next;
         pass_reg <= pass_next;
         fail_reg <= fail_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_reg_rdata = rdata_reg;
   assign o_ram_rdata = ram_rdata;
   assign o_bist_busy = (state_reg != ST_IDLE);

   property p_start_clears;
      @(posedge i_clk) disable iff (!rstn) start |=> go_reg && !pass_reg && !fail_reg;
   endproperty
   a_start_clears: assert property (p_start_clears) else $error("start left a result");

   property p_go_gated;
      @(posedge i_clk) disable iff (!rstn)
         $rose(go_reg) |-> $past(i_test_pin) && $past(full_ram_access_bit_reg);
   endproperty
   a_go_gated: assert property (p_go_gated) else $error("go set without test pin");

   property p_go_clears;
      @(posedge i_clk) disable iff (!rstn)
         (state_reg == ST_HOLD) ##1 (state_reg == ST_IDLE) |-> !go_reg;
   endproperty
   a_go_clears: assert property (p_go_clears) else $error("go stayed after finish");

   property p_one_result;
      @(posedge i_clk) disable iff (!rstn) !(pass_reg && fail_reg);
   endproperty
   a_one_result: assert property (p_one_result) else $error("pass and fail together");

   property p_fill_zero;
      @(posedge i_clk) disable iff (!rstn)
         (state_reg == ST_FILL && sel_reg == rbc_pkg::SEL_PATTERN)
         |-> ram_we && ram_wdata == rbc_pkg::DATA_ZERO;
   endproperty
   a_fill_zero: assert property (p_fill_zero) else $error("fill not zero");

   property p_fill_from_bottom;
      @(posedge i_clk) disable iff (!rstn)
         $rose(state_reg == ST_FILL) |-> addr_reg == 13'h0000;
   endproperty
   a_fill_from_bottom: assert property (p_fill_from_bottom) else $error("fill skips low");

   property p_zero_check;
      @(posedge i_clk) disable iff (!rstn)
         (state_reg == ST_CHK0 && ram_rdata != fill_data) |=> err_reg;
   endproperty
   a_zero_check: assert property (p_zero_check) else $error("zero miss lost");

   property p_pat_order;
      @(posedge i_clk) disable iff (!rstn)
         (state_reg == ST_PWR && pat_reg == 2'd0) |-> ram_wdata == rbc_pkg::PAT_ALT
         ##3 (state_reg == ST_PWR && ram_wdata == rbc_pkg::PAT_PAIR);
   endproperty
   a_pat_order: assert property (p_pat_order) else $error("pattern order wrong");

   property p_inv_nibble;
      @(posedge i_clk) disable iff (!rstn)
         (state_reg == ST_PCHK && pat_reg == 2'd3 && ram_rdata != rbc_pkg::PAT_NIB_INV)
         |=> err_reg;
   endproperty
   a_inv_nibble: assert property (p_inv_nibble) else $error("f0f0 miss lost");

   property p_starts;
      @(posedge i_clk) disable iff (!rstn) start |=> state_reg != ST_IDLE;
   endproperty
   a_starts: assert property (p_starts) else $error("start ignored");

   property p_pin_low_reads_zero;
      @(posedge i_clk) disable iff (!rstn) (i_reg_rd && !i_test_pin) |=> o_reg_rdata == 16'h0000;
   endproperty
   a_pin_low_reads_zero: assert property (p_pin_low_reads_zero) else $error("read w/o pin");

   property p_pattern_time;
      @(posedge i_clk) disable iff (!rstn)
         ($rose(pass_reg) && sel_reg == rbc_pkg::SEL_PATTERN) |-> $past(cnt_reg) == PAT_LIMIT;
   endproperty
   a_pattern_time: assert property (p_pattern_time) else $error("pattern passed early");

   c_pattern_pass: cover property (@(posedge i_clk) disable iff (!rstn)
      $rose(pass_reg) && sel_reg == rbc_pkg::SEL_PATTERN);
   c_forced_fail: cover property (@(posedge i_clk) disable iff (!rstn)
      $rose(fail_reg) && ffail_reg);
   c_check_zero_done: cover property (@(posedge i_clk) disable iff (!rstn)
      $fell(go_reg) && sel_reg == rbc_pkg::SEL_CHECK_ZERO);
endmodule : rbc_bist_ctrl
`default_nettype wire

// file: tb/rbc_host_model.sv
// Purpose: host side model driving the register port and host ram port
// Assumes: strobes are one-cycle pulses launched just after a rising edge
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module rbc_host_model
(
   input wire logic i_clk,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_addr,
   output logic [15:0] o_reg_wdata,
   output logic o_ram_we,
   output logic [12:0] o_ram_addr,
   output logic [15:0] o_ram_wdata,
   input wire logic [15:0] i_reg_rdata,
   input wire logic [15:0] i_ram_rdata
);
   logic [7:0] map_ptr;
   initial
   begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 8'h00;
      o_reg_wdata = 16'h0000;
      o_ram_we = 1'b0;
      o_ram_addr = 13'h0000;
      o_ram_wdata = 16'h0000;
      map_ptr = 8'h00;
   end
   task automatic set_ptr(input logic [7:0] a);
      map_ptr = a;
   endtask : set_ptr
   // a write of one to the go bit is how the host starts a test
   task automatic reg_write(input logic [15:0] d);
      @(posedge i_clk);
      o_reg_wr <= 1'b1;
      o_reg_addr <= map_ptr;
      o_reg_wdata <= d;
      @(posedge i_clk);
      o_reg_wr <= 1'b0;
      o_reg_addr <= ~map_ptr;
      o_reg_wdata <= ~d;
   endtask : reg_write
   task automatic reg_read(output logic [15:0] d);
      @(posedge i_clk);
      o_reg_rd <= 1'b1;
      o_reg_addr <= map_ptr;
      @(posedge i_clk);
      o_reg_rd <= 1'b0;
      o_reg_addr <= ~map_ptr;
      #1;
      d = i_reg_rdata;
   endtask : reg_read
   // pointer reloaded every poll, never trusted from before
   task automatic poll(output logic [15:0] d);
      set_ptr(8'h28);
      reg_read(d);
   endtask : poll
   task automatic ram_write(input logic [12:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_ram_we <= 1'b1;
      o_ram_addr <= a;
      o_ram_wdata <= d;
      @(posedge i_clk);
      o_ram_we <= 1'b0;
      o_ram_wdata <= ~d;
   endtask : ram_write
   task automatic ram_read(input logic [12:0] a, output logic [15:0] d);
      @(posedge i_clk);
      o_ram_addr <= a;
      @(posedge i_clk);
      #1;
      d = i_ram_rdata;
   endtask : ram_read
endmodule : rbc_host_model
`default_nettype wire

// file: tb/ram_bist_pattern_control_bench.sv
// Purpose: self-checking bench for the ram self-test control block
// Assumes: inc/dec and pattern runs are too long here, so they are aborted
// Notes: expectations come from a behavioural ram and register model
`timescale 1ns/1ns
`default_nettype none
module ram_bist_pattern_control_bench;
   logic i_clk;
   logic i_rstn;
   logic i_test_pin;
   logic reg_wr, reg_rd, ram_we, busy;
   logic [7:0] reg_addr;
   logic [12:0] ram_addr, a;
   logic [15:0] reg_wdata, reg_rdata, ram_wdata, ram_rdata, d;
   int err_count, cmp_count, seed;
   logic full_ram_access_bit, ffail;
   logic [2:0] sel_m;
   logic [15:0] fill;
   logic [15:0] hw[int];
   rbc_bist_ctrl #(.PATTERN_CYCLES(200000)) DUT (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_test_pin(i_test_pin), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_ram_we(ram_we),
      .i_ram_addr(ram_addr), .i_ram_wdata(ram_wdata), .o_ram_rdata(ram_rdata),
      .o_bist_busy(busy));
   rbc_host_model host (.i_clk(i_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
      .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_ram_we(ram_we),
      .o_ram_addr(ram_addr), .o_ram_wdata(ram_wdata), .i_reg_rdata(reg_rdata),
      .i_ram_rdata(ram_rdata));
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   task automatic check16(input string what, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : check16
   task automatic check1(input string what, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s: expected %b seen %b", what, e, g);
      end
   endtask : check1
   task automatic report_and_stop;
      if (err_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   function automatic logic [15:0] exp_reg(input logic go, input logic ps, input logic fl);
      return {full_ram_access_bit, ffail, sel_m, go, ps, fl, 8'h00};
   endfunction : exp_reg
   function automatic logic exp_bad(input logic [2:0] s);
      logic [15:0] t;
      logic bad;
      t = (s == rbc_pkg::SEL_CHECK_ONE) ? rbc_pkg::DATA_ONE : rbc_pkg::DATA_ZERO;
      bad = ffail;
      if (s == rbc_pkg::SEL_CHECK_ZERO || s == rbc_pkg::SEL_CHECK_ONE)
      begin
         if (fill != t) bad = 1'b1;
         foreach (hw[k]) if (hw[k] != t) bad = 1'b1;
      end
      return bad;
   endfunction : exp_bad
   task automatic do_reset;
      i_rstn <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_rstn <= 1'b1;
      full_ram_access_bit = 1'b0;
      ffail = 1'b0;
      sel_m = 3'h0;
      repeat (3) @(posedge i_clk);
   endtask : do_reset
   task automatic run_sel(input logic [2:0] s, input logic ff, input bit wait_done);
      int n;
      int want;
      logic bad;
      logic [15:0] r;
      ffail = ff;
      sel_m = s;
      want = 2;
      if (s == rbc_pkg::SEL_WRITE_ZERO || s == rbc_pkg::SEL_WRITE_ONE) want = 8192;
      if (s == rbc_pkg::SEL_CHECK_ZERO || s == rbc_pkg::SEL_CHECK_ONE) want = 16384;
      if (s == rbc_pkg::SEL_PATTERN || s == rbc_pkg::SEL_INC_DEC) want = 90000;
      bad = exp_bad(s);
      host.reg_write({1'b1, ff, s, 1'b1, 2'b00, 8'($random(seed))});
      #1;
      n = 0;
      if (want > 2)
      begin
         host.poll(r);
         check16("started", exp_reg(1'b1, 1'b0, 1'b0), r);
         // busy write must not disturb full_ram_access_bit or select
         host.reg_write(16'($random(seed)));
         n = 4;
      end
      if (!wait_done) return;
      while (busy === 1'b1 && n < 40000)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check1("duration", 1'b1, n >= want - 8 && n <= want + 8);
      if (s == rbc_pkg::SEL_WRITE_ZERO || s == rbc_pkg::SEL_WRITE_ONE)
      begin
         fill = (s == rbc_pkg::SEL_WRITE_ONE) ? rbc_pkg::DATA_ONE : rbc_pkg::DATA_ZERO;
         hw.delete();
      end
      host.poll(r);
      check16("result", exp_reg(1'b0, want > 2 && !bad, want > 2 && bad), r);
   endtask : run_sel
   initial
   begin
      repeat (95000) @(posedge i_clk);
      err_count++;
      report_and_stop();
   end
   initial
   begin
      i_rstn = 1'b0;
      i_test_pin = 1'b1;
      err_count = 0;
      cmp_count = 0;
      seed = 32'h65edbaf1;
      fill = 16'h0000;
      do_reset();
      host.poll(d);
      check16("reset value", rbc_pkg::REG_RESET_VALUE, d);
      i_test_pin <= 1'b0;
      host.reg_write(16'h8000);
      host.poll(d);
      check16("pin low read", 16'h0000, d);
      i_test_pin <= 1'b1;
      host.poll(d);
      check16("pin low write", 16'h0000, d);
      host.reg_write(16'h8C00);
      full_ram_access_bit = 1'b1;
      sel_m = rbc_pkg::SEL_PATTERN;
      host.poll(d);
      check16("go with full_ram_access_bit", exp_reg(1'b0, 1'b0, 1'b0), d);
      i_test_pin <= 1'b0;
      host.reg_write(16'h8C00);
      i_test_pin <= 1'b1;
      // any pointer but the self-test register, so the write never lands
      host.set_ptr(8'h29 + 8'($unsigned($random(seed)) % 200));
      host.reg_write(16'hFFFF);
      host.reg_write(16'h8BFF);
      host.poll(d);
      check16("refused writes", exp_reg(1'b0, 1'b0, 1'b0), d);
      check1("idle busy", 1'b0, busy);
      run_sel(rbc_pkg::SEL_WRITE_ONE, 1'b0, 1'b1);
      a = 13'h0052 + 13'($unsigned($random(seed)) % 8000);
      host.ram_read(a, d);
      check16("ram after ones", rbc_pkg::DATA_ONE, d);
      // hidden low words were filled too, and host writes there are dropped
      a = 13'($unsigned($random(seed)) % 82);
      host.ram_write(a, 16'($random(seed)));
      host.ram_read(a, d);
      check16("low ram", rbc_pkg::DATA_ONE, d);
      run_sel(rbc_pkg::SEL_CHECK_ONE, 1'b0, 1'b1);
      repeat (3)
      begin
         a = 13'h0052 + 13'($unsigned($random(seed)) % 8000);
         d = 16'($random(seed));
         host.ram_write(a, d);
         hw[int'(a)] = d;
         host.ram_read(a, d);
         check16("host ram", hw[int'(a)], d);
      end
      run_sel(rbc_pkg::SEL_CHECK_ONE, 1'b0, 1'b1);
      run_sel(rbc_pkg::SEL_WRITE_ZERO, 1'b1, 1'b1);
      run_sel(rbc_pkg::SEL_CHECK_ZERO, 1'b0, 1'b1);
      run_sel(rbc_pkg::SEL_IDLE_LO, 1'b0, 1'b1);
      run_sel(3'h7, 1'b0, 1'b1);
      run_sel(rbc_pkg::SEL_INC_DEC, 1'b0, 1'b0);
      do_reset();
      host.reg_write(16'h8000);
      full_ram_access_bit = 1'b1;
      run_sel(rbc_pkg::SEL_PATTERN, 1'b0, 1'b0);
      // fill alone is 8192 cycles, so still busy well past it
      repeat (9000) @(posedge i_clk);
      #1;
      check1("pattern busy", 1'b1, busy);
      do_reset();
      check1("abort busy", 1'b0, busy);
      host.poll(d);
      check16("abort reg", 16'h0000, d);
      report_and_stop();
   end
endmodule : ram_bist_pattern_control_bench
`default_nettype wire
